/* incremental_position_counter_tb_top.sv */
// Purpose: self-checking bench for ipc_counter
// Assumes: clk_en_i held high
// Notes: rows cover both counting modes
`default_nettype none
module incremental_position_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {bit sel; bit up; int n; logic [31:0] pos;} ipc_row_t;
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, awready, wready, bvalid, arready, rvalid, cntdir;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] abs_raw_i = 32'h0, wdata = 32'h0, rdata, rd, position;
  logic [1:0] bresp, rresp, rs;
  ipc_pkg::ipc_pins_t pins;
  int fail_count = 0, n_checks = 0, cyc = 0;
  ipc_row_t rows [4] = '{'{0, 1, 6, 32'h6}, '{0, 0, 9, 32'hffff_fffd}, '{1, 1, 5, 32'h2}, '{1, 0, 4, 32'hffff_fffe}};
  always #4 ref_clk_i = ~ref_clk_i;
  ipc_encoder_model enc (.clk_i(ref_clk_i), .pins_o(pins));
  ipc_counter DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(1'b1), .pins_i(pins), .abs_raw_i(abs_raw_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .position_o(position), .mode_cntdir_o(cntdir));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // wt: cycles bready stays low, so the slave must hold its answer
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = ipc_pkg::RESP_OKAY,
                     input int wt = 0);
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (wt == 0);
    forever begin
      @(posedge ref_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bready && bvalid) break;
      if (wt > 0) wt--;
      if (wt == 0) bready <= 1'b1;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : axw
  task automatic axr(input logic [7:0] a, input int wt = 0);
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (wt == 0);
    forever begin
      @(posedge ref_clk_i);
      if (arready) arvalid <= 1'b0;
      if (rready && rvalid) break;
      if (wt > 0) wt--;
      if (wt == 0) rready <= 1'b1;
    end
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask : axr
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    chk("reset pos", 32'h0, position);
    rstn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    axr(ipc_pkg::ADDR_CTRL);
    chk("ctrl reset", ipc_pkg::CTRL_RST, rd);
    axr(ipc_pkg::ADDR_OFFSET);
    chk("offset reset", ipc_pkg::OFFSET_RST, rd);
    foreach (rows[i]) begin
      enc.level(rows[i].sel, 1'b0, 12);
      if (rows[i].sel) enc.pulses(rows[i].n, !rows[i].up);
      else enc.quad(rows[i].n, rows[i].up);
      repeat (8) @(posedge ref_clk_i);
      chk("position", rows[i].pos, position);
      axr(ipc_pkg::ADDR_COUNT);
      chk("count reg", rows[i].pos, rd);
      chk("mode", {31'h0, rows[i].sel}, {31'h0, cntdir});
    end
    axr(ipc_pkg::ADDR_STATUS);
    chk("status", 32'h6, rd);
    axw(ipc_pkg::ADDR_OFFSET, 32'h10, ipc_pkg::RESP_OKAY, 3);
    repeat (8) @(posedge ref_clk_i);
    chk("no offset", 32'hffff_fffe, position);
    abs_raw_i <= 32'h100;
    axw(ipc_pkg::ADDR_CTRL, 32'h1);
    repeat (8) @(posedge ref_clk_i);
    chk("abs pos", 32'hf0, position);
    axr(ipc_pkg::ADDR_POS, 3);
    chk("pos reg", 32'hf0, rd);
    axr(ipc_pkg::ADDR_RAW);
    chk("raw reg", 32'h100, rd);
    axw(ipc_pkg::ADDR_CTRL, 32'h0);
    axr(8'h40);
    chk("unmapped", {30'h0, ipc_pkg::RESP_SLVERR}, {30'h0, rs});
    enc.level(1'b1, 1'b1, ipc_pkg::CLR_CYC - 20);
    enc.level(1'b1, 1'b0, 10);
    chk("short clear", 32'hffff_fffe, position);
    enc.level(1'b1, 1'b1, ipc_pkg::CLR_CYC + 20);
    enc.level(1'b1, 1'b0, 10);
    chk("clear", 32'h0, position);
    enc.pulses(3, 1'b0);
    repeat (8) @(posedge ref_clk_i);
    chk("after clear", 32'h3, position);
    axw(ipc_pkg::ADDR_CTRL, 32'h2);
    repeat (4) @(posedge ref_clk_i);
    chk("sw clear", 32'h0, position);
    axw(ipc_pkg::ADDR_COUNT, 32'h55);
    axr(ipc_pkg::ADDR_COUNT);
    chk("ro count", 32'h0, rd);
    axw(8'h40, 32'h1, ipc_pkg::RESP_SLVERR);
    report_and_stop();
  end
endmodule : incremental_position_counter_tb_top
`default_nettype wire

/* ipc_counter.sv */
// Purpose: incremental position counter with quadrature and count/direction modes
// Assumes: pins synchronous-ish, resynchronised here; axi4-lite slave registers
// Notes:
// Notes on behaviour
// - encoder supplies two tracks ninety degrees apart, optional zero track; count derived.
// - mode select low or open gives quadrature decoding.
// - mode select high gives count and direction counting.
// - count/direction mode steps once on each rising count pulse edge.
// - direction low counts up, direction high counts down.
// - clear pulse zeroes the count; source holds it long enough.
// - absolute mode reports raw value minus stored zero offset.
// - incremental operation applies no zero offset correction.
//
// Chosen here: register access over AXI4-Lite and the address map.
`default_nettype none
module ipc_counter (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // field pins
  input wire ipc_pkg::ipc_pins_t pins_i,
  input wire logic [31:0] abs_raw_i,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // position and mode out
  output logic [31:0] position_o,
  output logic mode_cntdir_o
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_m_r, rst_s_r;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end
  wire logic rstn = rst_s_r;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  ipc_pkg::ipc_pins_t s1_r, s2_r, s3_r;
  always_ff @(posedge ref_clk_i or negedge rstn) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (clk_en_i) begin
      s1_r <= pins_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ------------------------------------------------------------
  // counting
  // ------------------------------------------------------------
  ipc_pkg::ipc_mode_t mode_r, mode_nxt;
  logic [31:0] count_r, count_nxt;
  localparam int CLR_W = ipc_pkg::CLR_CNT_W;
  logic [CLR_W-1:0] clr_cnt_r, clr_cnt_nxt;
  logic [31:0] ctrl_r, ctrl_nxt, offset_r, offset_nxt, pos_r, pos_nxt;
  logic clr_done_r, clr_done_nxt;
  logic cntdir_r, cntdir_nxt;
  logic [1:0] qa, qb;
  logic step, up;

  always_comb begin
    mode_nxt = s2_r.counting_mode_select ? ipc_pkg::IPC_CNTDIR : ipc_pkg::IPC_QUAD;
    cntdir_nxt = (mode_nxt == ipc_pkg::IPC_CNTDIR);
    qa = {s3_r.encoder_track_first, s3_r.encoder_track_second};
    qb = {s2_r.encoder_track_first, s2_r.encoder_track_second};
    step = 1'b0;
    up = 1'b1;
    case (mode_r)
      ipc_pkg::IPC_QUAD: begin
        // gray sequence 00-01-11-10 counts up; double jumps ignored
        if ((qa ^ qb) == 2'b01 || (qa ^ qb) == 2'b10) begin
          step = 1'b1;
          up = (qa[1] ^ qb[0]);
        end
      end
      ipc_pkg::IPC_CNTDIR: begin
        step = s2_r.count_pulse & ~s3_r.count_pulse;
        up = ~s2_r.down;
      end
      default: begin
        step = 1'b0;
      end
    endcase
    count_nxt = count_r;
    if (step) count_nxt = up ? count_r + 32'h1 : count_r - 32'h1;
    clr_cnt_nxt = s2_r.clear ? ((clr_cnt_r == CLR_W'(ipc_pkg::CLR_CYC)) ? clr_cnt_r : clr_cnt_r + 1'b1) : '0;
    clr_done_nxt = (clr_cnt_r == CLR_W'(ipc_pkg::CLR_CYC - 1)) & s2_r.clear;
    if (clr_done_r || ctrl_r[ipc_pkg::CTRL_SWCLR_BIT]) count_nxt = '0;
    pos_nxt = ctrl_r[ipc_pkg::CTRL_ABS_BIT] ? abs_raw_i - offset_r : count_r;
  end

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic awr_r, awr_nxt, wr_r, wr_nxt, arr_r, arr_nxt;
  logic [7:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;

  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    ctrl_nxt = ctrl_r;
    ctrl_nxt[ipc_pkg::CTRL_SWCLR_BIT] = 1'b0;
    offset_nxt = offset_r;
    if (s_axi_awvalid && awr_r) begin
      aw_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_r) begin
      w_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (aw_r && w_r) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = ipc_pkg::RESP_OKAY;
      case ({awa_r[7:2], 2'b00})
        ipc_pkg::ADDR_CTRL: ctrl_nxt = merge(ctrl_r, wd_r, ws_r) & 32'h0000_0003;
        ipc_pkg::ADDR_OFFSET: offset_nxt = merge(offset_r, wd_r, ws_r);
        ipc_pkg::ADDR_COUNT, ipc_pkg::ADDR_POS, ipc_pkg::ADDR_RAW, ipc_pkg::ADDR_STATUS: br_nxt = ipc_pkg::RESP_OKAY;
        default: br_nxt = ipc_pkg::RESP_SLVERR;
      endcase
    end
    if (bv_r && s_axi_bready) bv_nxt = 1'b0;
    if (s_axi_arvalid && arr_r) begin
      rv_nxt = 1'b1;
      rr_nxt = ipc_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        ipc_pkg::ADDR_CTRL: rd_nxt = ctrl_r;
        ipc_pkg::ADDR_COUNT: rd_nxt = count_r;
        ipc_pkg::ADDR_OFFSET: rd_nxt = offset_r;
        ipc_pkg::ADDR_POS: rd_nxt = pos_r;
        ipc_pkg::ADDR_RAW: rd_nxt = abs_raw_i;
        ipc_pkg::ADDR_STATUS: rd_nxt = {27'h0, s2_r.clear, s2_r.zero_pulse, s2_r.down,
                                        mode_r == ipc_pkg::IPC_CNTDIR, s2_r.encoder_track_first};
        default: begin
          rd_nxt = 32'h0;
          rr_nxt = ipc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    // readies registered, low while busy or in reset
    awr_nxt = ~aw_nxt & ~bv_nxt;
    wr_nxt = ~w_nxt & ~bv_nxt;
    arr_nxt = ~rv_nxt;
  end

  always_ff @(posedge ref_clk_i or negedge rstn) begin
    if (!rstn) begin
      mode_r <= ipc_pkg::IPC_QUAD;
      count_r <= '0;
      clr_cnt_r <= '0;
      clr_done_r <= 1'b0;
      pos_r <= '0;
      ctrl_r <= ipc_pkg::CTRL_RST;
      offset_r <= ipc_pkg::OFFSET_RST;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awa_r <= '0;
      wd_r <= '0;
      ws_r <= '0;
      bv_r <= 1'b0;
      br_r <= '0;
      rv_r <= 1'b0;
      rd_r <= '0;
      rr_r <= '0;
      cntdir_r <= 1'b0;
      awr_r <= 1'b0;
      wr_r <= 1'b0;
      arr_r <= 1'b0;
    end else if (clk_en_i) begin
      mode_r <= mode_nxt;
      count_r <= count_nxt;
      clr_cnt_r <= clr_cnt_nxt;
      clr_done_r <= clr_done_nxt;
      pos_r <= pos_nxt;
      ctrl_r <= ctrl_nxt;
      offset_r <= offset_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      bv_r <= bv_nxt;
      br_r <= br_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rr_r <= rr_nxt;
      cntdir_r <= cntdir_nxt;
      awr_r <= awr_nxt;
      wr_r <= wr_nxt;
      arr_r <= arr_nxt;
    end
  end

  assign s_axi_awready = awr_r;
  assign s_axi_wready = wr_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = br_r;
  assign s_axi_arready = arr_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = rd_r;
  assign s_axi_rresp = rr_r;
  assign position_o = pos_r;
  assign mode_cntdir_o = cntdir_r;
endmodule : ipc_counter
`default_nettype wire

/* ipc_encoder_model.sv */
// Purpose: encoder and count pulse source
// Assumes: driven from the bench main process
// Notes: clean edges only
`default_nettype none
module ipc_encoder_model (
  // clock
  input wire logic clk_i,
  // field pins
  output var ipc_pkg::ipc_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r = 2'h0;
  initial pins_o = '0;
  // second track leads when counting up
  task automatic quad(input int n, input bit up);
    repeat (n) begin
      ph_r = up ? ph_r + 2'h1 : ph_r - 2'h1;
      repeat (6) @(posedge clk_i);
      {pins_o.encoder_track_first, pins_o.encoder_track_second} <= ph_r ^ (ph_r >> 1);
      pins_o.zero_pulse <= (ph_r == 2'h0);
    end
  endtask : quad
  // debounced pulses, one edge each way
  task automatic pulses(input int n, input bit dn);
    @(posedge clk_i) pins_o.down <= dn;
    repeat (n) begin
      repeat (8) @(posedge clk_i);
      pins_o.count_pulse <= 1'b1;
      repeat (8) @(posedge clk_i);
      pins_o.count_pulse <= 1'b0;
    end
  endtask : pulses
  task automatic level(input bit sel, input bit clr, input int cyc);
    @(posedge clk_i);
    pins_o.counting_mode_select <= sel;
    pins_o.clear <= clr;
    repeat (cyc) @(posedge clk_i);
  endtask : level
endmodule : ipc_encoder_model
`default_nettype wire

/* ipc_monitor.sv */
// Purpose: port checker for ipc_counter
// Assumes: clk_en_i high, abs mode off during clears
// Notes: bound at the foot
`default_nettype none
module ipc_monitor (
  // clock, reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // pins, read bus and write response handshake
  input wire ipc_pkg::ipc_pins_t pins_i,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // outputs
  input wire logic [31:0] position_o,
  input wire logic mode_cntdir_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] clr_r;
  logic [7:0] clr_nxt;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // cycles the clear pin has been held
  always_comb clr_nxt = !pins_i.clear ? 8'h00 : (clr_r == 8'hff ? clr_r : clr_r + 8'h01);
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clr_r <= 8'h00;
    end else begin
      clr_r <= clr_nxt;
    end
  end
  sequence pulse_s;
    mode_cntdir_o && !pins_i.clear && $rose(pins_i.count_pulse);
  endsequence
  sequence step_s;
    (position_o - $past(position_o, 6)) == (pins_i.down ? 32'hffff_ffff : 32'h1);
  endsequence
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer unstable");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  r_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h05 |=>
    s_axi_rresp == ipc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped not refused");
  quad_select_a:
    assert property ((!pins_i.counting_mode_select && clk_en_i) [*8] |-> !mode_cntdir_o) else $error("no quad");
  cntdir_select_a:
    assert property ((pins_i.counting_mode_select && clk_en_i) [*8] |-> mode_cntdir_o) else $error("no cntdir");
  clear_zero_a:
    assert property (clr_r == 8'h8c |-> position_o == 32'h0) else $error("clear missed");
  pulse_step_a:
    assert property (pulse_s |-> ##6 step_s) else $error("pulse step wrong");
endmodule : ipc_monitor
bind ipc_counter ipc_monitor u_mon (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i), .pins_i(pins_i),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .position_o(position_o), .mode_cntdir_o(mode_cntdir_o));
`default_nettype wire

/* ipc_pkg.sv */
// Purpose: shared constants and types for the incremental position counter
// Assumes: 32-bit axi4-lite register access, 125 MHz clock
// Notes: offsets are byte addresses of aligned words
`default_nettype none
package ipc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_POS = 8'h0c;
  localparam logic [7:0] ADDR_RAW = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam int CTRL_ABS_BIT = 0;
  localparam int CTRL_SWCLR_BIT = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int CLR_MIN_US = 1;
  localparam int CLR_CYC = CLR_MIN_US * CLK_MHZ;
  localparam int CLR_CNT_W = 8;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    IPC_QUAD = 2'b01,
    IPC_CNTDIR = 2'b10
  } ipc_mode_t;
  typedef struct packed {
    logic encoder_track_first;
    logic encoder_track_second;
    logic zero_pulse;
    logic count_pulse;
    logic down;
    logic clear;
    logic counting_mode_select;
  } ipc_pins_t;
endpackage : ipc_pkg
`default_nettype wire
